// [emt_cfg_if.sv]
// Interface carrying the timing and mode fields to the sequencer.
`timescale 1ns/1ps
interface emt_cfg_if;
	logic [1:0] setup_sel;
	logic [3:0] width_sel;
	logic [1:0] hold_sel;
	logic [2:0] mode_sel;
	logic [1:0] ale_sel;
	modport regs (output setup_sel, width_sel, hold_sel, mode_sel, ale_sel);
	modport seq (input setup_sel, width_sel, hold_sel, mode_sel, ale_sel);
endinterface

// [emt_mem_model.sv]
// Behavioural external SRAM with an address latch for the shared bus.
`timescale 1ns/1ps
module emt_mem_model (
	// Clock and bus mode.
	input wire logic clk_sys,
	input wire logic muxed,
	// Memory pins.
	input wire logic [15:0] mem_addr_q,
	input wire logic [7:0] mem_data_out_q,
	input wire logic mem_ale_q,
	input wire logic mem_rd_n_q,
	input wire logic mem_wr_n_q,
	output logic [7:0] mem_data_in
);
	logic [7:0] mem [256];
	logic [7:0] lat = 8'h00;
	logic [7:0] last = 8'h00;
	wire logic [7:0] idx = muxed ? lat : mem_addr_q[7:0];
	always @(posedge clk_sys) begin
		// The latch loads the data lines on each clock edge while the strobe is high.
		if (mem_ale_q)
			lat <= mem_data_out_q;
		if (!mem_wr_n_q)
			mem[idx] <= mem_data_out_q;
		if (!mem_rd_n_q)
			last <= mem[idx];
	end
	// Released lines show the inverse of the last value, not a stale one.
	always @* begin
		mem_data_in = mem_rd_n_q ? ~last : mem[idx];
	end
endmodule

// [emt_pkg.sv]
// Package with register map, field layout and timing constants.
package emt_pkg;
	localparam logic [7:0] EMT_TIMING_ADDR = 8'h84;
	localparam logic [7:0] EMT_CONFIG_ADDR = 8'h85;
	localparam logic [7:0] EMT_TIMING_RST = 8'hFF;
	localparam logic [7:0] EMT_CONFIG_RST = 8'h03;
	localparam int EMT_SETUP_HI = 7;
	localparam int EMT_SETUP_LO = 6;
	localparam int EMT_WIDTH_HI = 5;
	localparam int EMT_WIDTH_LO = 2;
	localparam int EMT_HOLD_HI = 1;
	localparam int EMT_HOLD_LO = 0;
	localparam int EMT_MODE_HI = 4;
	localparam int EMT_MODE_LO = 2;
	localparam int EMT_ALE_HI = 1;
	localparam int EMT_ALE_LO = 0;
	localparam logic [2:0] EMT_MODE_MUX_A = 3'h1;
	localparam logic [2:0] EMT_MODE_MUX_BANK = 3'h2;
	localparam logic [2:0] EMT_MODE_MUX_C = 3'h3;
	localparam logic [2:0] EMT_MODE_SEP_A = 3'h5;
	localparam logic [2:0] EMT_MODE_SEP_BANK = 3'h6;
	localparam logic [2:0] EMT_MODE_SEP_C = 3'h7;
	localparam int EMT_BASE_CYCLES = 4;
	typedef enum logic [2:0] {
		EMT_IDLE, EMT_ALE_H, EMT_ALE_L, EMT_SETUP, EMT_STROBE, EMT_HOLD,
		EMT_DONE
	} emt_state_t;
endpackage

// [emt_regs.sv]
// Special-function register slave holding timing and mode registers.
`timescale 1ns/1ps
module emt_regs
	import emt_pkg::*;
(
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst,
	// Register port.
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata_q,
	// Fields.
	emt_cfg_if.regs cfg
);
	logic [7:0] timing_q, timing_d, config_q, config_d, rdata_d;

	// The page register is not decoded, so every page reaches the map.
	always_comb begin
		timing_d = timing_q;
		config_d = config_q;
		rdata_d = sfr_rdata_q;
		if (sfr_wr && sfr_addr == EMT_TIMING_ADDR) begin
			timing_d = sfr_wdata;
		end
		if (sfr_wr && sfr_addr == EMT_CONFIG_ADDR) begin
			config_d = {3'h0, sfr_wdata[4:0]};
		end
		if (sfr_rd) begin
			unique case (sfr_addr)
				EMT_TIMING_ADDR: rdata_d = timing_q;
				EMT_CONFIG_ADDR: rdata_d = config_q;
				default: rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			timing_q <= EMT_TIMING_RST;
			config_q <= EMT_CONFIG_RST;
			sfr_rdata_q <= 8'h00;
		end else begin
			timing_q <= timing_d;
			config_q <= config_d;
			sfr_rdata_q <= rdata_d;
		end
	end

	assign cfg.setup_sel = timing_q[EMT_SETUP_HI:EMT_SETUP_LO];
	assign cfg.width_sel = timing_q[EMT_WIDTH_HI:EMT_WIDTH_LO];
	assign cfg.hold_sel = timing_q[EMT_HOLD_HI:EMT_HOLD_LO];
	assign cfg.mode_sel = config_q[EMT_MODE_HI:EMT_MODE_LO];
	assign cfg.ale_sel = config_q[EMT_ALE_HI:EMT_ALE_LO];

	reset_value_a: assert property (@(posedge clk_sys)
		$fell(rst) |-> timing_q == EMT_TIMING_RST)
		else $error("timing register not all ones after reset");
	page_free_write_a: assert property (@(posedge clk_sys)
		disable iff (rst) sfr_wr && sfr_addr == EMT_TIMING_ADDR |=>
		timing_q == $past(sfr_wdata))
		else $error("timing register write lost");
endmodule

// [emt_top.sv]
// External data memory bus timing sequencer with its register slave.
`timescale 1ns/1ps
module emt_top
	import emt_pkg::*;
(
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst,
	// Register port.
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata_q,
	// Core access request.
	input wire logic acc_req,
	input wire logic acc_write,
	input wire logic acc_short,
	input wire logic [15:0] acc_addr,
	input wire logic [7:0] acc_wdata,
	output logic acc_done_q,
	output logic [7:0] acc_rdata_q,
	// Memory pins.
	output logic [15:0] mem_addr_q,
	output logic mem_addr_hi_oe_q,
	output logic [7:0] mem_data_out_q,
	output logic mem_data_oe_q,
	input wire logic [7:0] mem_data_in,
	output logic mem_ale_q,
	output logic mem_rd_n_q,
	output logic mem_wr_n_q
);
	emt_cfg_if cfg ();
	emt_state_t state_q, state_d;
	logic [3:0] cnt_q, cnt_d;
	logic wr_q, wr_d, mux_q, mux_d, hi_q, hi_d;
	logic [15:0] addr_q, addr_d, pin_addr_d;
	logic [7:0] wdat_q, wdat_d, rdat_d, dout_d;
	logic [7:0] din_s1_q, din_s2_q;
	logic done_d, ale_d, rd_n_d, wr_n_d, doe_d, hioe_d, mux_now, hi_now;
	default clocking emt_cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	emt_regs u_regs (
		.clk_sys(clk_sys),
		.rst(rst),
		.sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd),
		.sfr_addr(sfr_addr),
		.sfr_wdata(sfr_wdata),
		.sfr_rdata_q(sfr_rdata_q),
		.cfg(cfg.regs)
	);

	// Mode decode: multiplexed codes 001..011, separate codes 000 and 100..111.
	always_comb begin
		mux_now = cfg.mode_sel == EMT_MODE_MUX_A ||
			cfg.mode_sel == EMT_MODE_MUX_BANK ||
			cfg.mode_sel == EMT_MODE_MUX_C;
		// Short accesses drive the upper byte only in the banked modes.
		hi_now = !acc_short || cfg.mode_sel == EMT_MODE_SEP_BANK ||
			cfg.mode_sel == EMT_MODE_MUX_BANK;
	end

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		wr_d = wr_q;
		mux_d = mux_q;
		hi_d = hi_q;
		addr_d = addr_q;
		wdat_d = wdat_q;
		rdat_d = acc_rdata_q;
		done_d = 1'b0;
		unique case (state_q)
			EMT_IDLE: begin
				if (acc_req) begin
					wr_d = acc_write;
					mux_d = mux_now;
					hi_d = hi_now;
					addr_d = acc_addr;
					wdat_d = acc_wdata;
					if (mux_now) begin
						state_d = EMT_ALE_H;
						cnt_d = {2'h0, cfg.ale_sel};
					end else begin
						state_d = EMT_SETUP;
						cnt_d = {2'h0, cfg.setup_sel};
					end
				end
			end
			EMT_ALE_H: begin
				if (cnt_q == 4'h0) begin
					state_d = EMT_ALE_L;
					cnt_d = {2'h0, cfg.ale_sel};
				end else begin
					cnt_d = cnt_q - 4'h1;
				end
			end
			EMT_ALE_L: begin
				if (cnt_q == 4'h0) begin
					state_d = EMT_SETUP;
					cnt_d = {2'h0, cfg.setup_sel};
				end else begin
					cnt_d = cnt_q - 4'h1;
				end
			end
			EMT_SETUP: begin
				// One pass through this state is one of the four fixed base cycles.
				if (cnt_q == 4'h0) begin
					state_d = EMT_STROBE;
					cnt_d = cfg.width_sel;
				end else begin
					cnt_d = cnt_q - 4'h1;
				end
			end
			EMT_STROBE: begin
				if (cnt_q == 4'h0) begin
					// Pin data lags two flops; short strobes read stale data.
					if (!wr_q) begin
						rdat_d = din_s2_q;
					end
					state_d = EMT_HOLD;
					cnt_d = {2'h0, cfg.hold_sel};
				end else begin
					cnt_d = cnt_q - 4'h1;
				end
			end
			EMT_HOLD: begin
				if (cnt_q == 4'h0) begin
					state_d = EMT_DONE;
				end else begin
					cnt_d = cnt_q - 4'h1;
				end
			end
			EMT_DONE: begin
				done_d = 1'b1;
				state_d = EMT_IDLE;
			end
		endcase
	end

	// Pin values follow the next state so that every pin is a register.
	always_comb begin
		ale_d = state_d == EMT_ALE_H && mux_d;
		rd_n_d = !(state_d == EMT_STROBE && !wr_d);
		wr_n_d = !(state_d == EMT_STROBE && wr_d);
		hioe_d = state_d != EMT_IDLE && hi_d;
		pin_addr_d = (state_d == EMT_IDLE) ? mem_addr_q : addr_d;
		if (mux_d && state_d == EMT_ALE_H) begin
			doe_d = 1'b1;
			dout_d = addr_d[7:0];
		end else begin
			// First setup and last hold cycles are base cycles: no data.
			doe_d = wr_d && ((state_d == EMT_SETUP &&
				cnt_d != {2'h0, cfg.setup_sel}) ||
				state_d == EMT_STROBE ||
				(state_d == EMT_HOLD && cnt_d != 4'h0));
			dout_d = wdat_d;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_q <= EMT_IDLE;
			cnt_q <= 4'h0;
			wr_q <= 1'b0;
			mux_q <= 1'b0;
			hi_q <= 1'b0;
			addr_q <= 16'h0000;
			wdat_q <= 8'h00;
			din_s1_q <= 8'h00;
			din_s2_q <= 8'h00;
			acc_done_q <= 1'b0;
			acc_rdata_q <= 8'h00;
			mem_addr_q <= 16'h0000;
			mem_addr_hi_oe_q <= 1'b0;
			mem_data_out_q <= 8'h00;
			mem_data_oe_q <= 1'b0;
			mem_ale_q <= 1'b0;
			mem_rd_n_q <= 1'b1;
			mem_wr_n_q <= 1'b1;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			wr_q <= wr_d;
			mux_q <= mux_d;
			hi_q <= hi_d;
			addr_q <= addr_d;
			wdat_q <= wdat_d;
			din_s1_q <= mem_data_in;
			din_s2_q <= din_s1_q;
			acc_done_q <= done_d;
			acc_rdata_q <= rdat_d;
			mem_addr_q <= pin_addr_d;
			mem_addr_hi_oe_q <= hioe_d;
			mem_data_out_q <= dout_d;
			mem_data_oe_q <= doe_d;
			mem_ale_q <= ale_d;
			mem_rd_n_q <= rd_n_d;
			mem_wr_n_q <= wr_n_d;
		end
	end

	// Helper counter of cycles spent in the current access.
	logic [5:0] acc_cyc_q;
	always_ff @(posedge clk_sys) begin
		if (rst || state_q == EMT_IDLE) begin
			acc_cyc_q <= 6'h00;
		end else begin
			acc_cyc_q <= acc_cyc_q + 6'h01;
		end
	end

	one_strobe_a: assert property (!(!mem_rd_n_q && !mem_wr_n_q))
		else $error("read and write strobes asserted together");
	strobe_width_a: assert property ($fell(mem_wr_n_q) &&
		cfg.width_sel == 4'h0 |=> mem_wr_n_q)
		else $error("one cycle strobe too long");
	ale_high_a: assert property ($rose(mem_ale_q) &&
		cfg.ale_sel == 2'h0 |=> !mem_ale_q)
		else $error("latch strobe high too long");
	ale_low_gap_a: assert property ($fell(mem_ale_q) |->
		mem_rd_n_q && mem_wr_n_q)
		else $error("strobe asserted as latch fell");
	mux_mode_a: assert property ($rose(mem_ale_q) |-> mux_q &&
		mem_data_oe_q && mem_data_out_q == addr_q[7:0])
		else $error("low address missing under latch strobe");
	sep_no_ale_a: assert property (state_q != EMT_IDLE && !mux_q |->
		!mem_ale_q)
		else $error("latch strobe in separate mode");
	min_access_a: assert property (acc_done_q && !mux_q |->
		acc_cyc_q == {4'h0, cfg.setup_sel} + {2'h0, cfg.width_sel} +
		{4'h0, cfg.hold_sel} + 6'(EMT_BASE_CYCLES))
		else $error("separate pin access length wrong");
	mux_access_a: assert property (acc_done_q && mux_q |->
		acc_cyc_q == {4'h0, cfg.setup_sel} + {2'h0, cfg.width_sel} +
		{4'h0, cfg.hold_sel} + {3'h0, cfg.ale_sel, 1'b0} +
		6'(EMT_BASE_CYCLES + 2))
		else $error("multiplexed access length wrong");
	wdata_setup_a: assert property ($rose(mem_wr_n_q) |->
		$past(mem_data_oe_q))
		else $error("write data not driven at strobe end");
	wdata_lead_a: assert property ($fell(mem_wr_n_q) &&
		cfg.setup_sel == 2'h0 |-> !$past(mem_data_oe_q))
		else $error("write data driven before a zero setup");
	wdata_hold_a: assert property ($rose(mem_wr_n_q) &&
		cfg.hold_sel != 2'h0 |-> mem_data_oe_q)
		else $error("write data dropped during hold");
	wdata_hold_zero_a: assert property ($rose(mem_wr_n_q) &&
		cfg.hold_sel == 2'h0 |-> !mem_data_oe_q)
		else $error("write data held past a zero hold");
	setup_idle_a: assert property (state_q == EMT_SETUP |->
		mem_rd_n_q && mem_wr_n_q)
		else $error("strobe active in setup");
	hold_idle_a: assert property (state_q == EMT_HOLD |->
		mem_rd_n_q && mem_wr_n_q)
		else $error("strobe active in hold");
	read_cov: cover property (@(posedge clk_sys) disable iff (rst)
		$rose(mem_rd_n_q) ##[1:8] acc_done_q);
	write_cov: cover property (@(posedge clk_sys) disable iff (rst)
		$rose(mem_wr_n_q) ##[1:8] acc_done_q);
	mux_cov: cover property (@(posedge clk_sys) disable iff (rst)
		$fell(mem_ale_q) ##[1:8] !mem_wr_n_q);
endmodule

// [tb_top.sv]
// Self-checking bench for the external memory timing block.
`timescale 1ns/1ps
module tb_top;
	import emt_pkg::*;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic sfr_wr = 1'b0;
	logic sfr_rd = 1'b0;
	logic [7:0] sfr_addr = 8'h00;
	logic [7:0] sfr_wdata = 8'h00;
	logic [7:0] sfr_rdata_q;
	logic acc_req = 1'b0;
	logic acc_write = 1'b0;
	logic acc_short = 1'b0;
	logic [15:0] acc_addr = 16'h0000;
	logic [7:0] acc_wdata = 8'h00;
	logic acc_done_q, mem_addr_hi_oe_q, mem_data_oe_q, mem_ale_q;
	logic mem_rd_n_q, mem_wr_n_q, muxed;
	logic [7:0] acc_rdata_q, mem_data_out_q, mem_data_in, rv;
	logic [15:0] mem_addr_q;
	int err_count = 0;
	int num_checks = 0;
	int lat_c, sw_c, al_c, bs_c, bw_c, ba_c, ho_c, wd_c, ad_c, xl, xa;
	logic [7:0] tms [6] = '{8'h00, 8'h5A, 8'hFF, 8'h00, 8'h5A, 8'h8D};
	logic [7:0] cfs [6] = '{8'h14, 8'h18, 8'h1C, 8'h04, 8'h0B, 8'h0D};
	logic shs [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
	always #4 clk_sys = ~clk_sys;
	emt_top dut (.clk_sys(clk_sys), .rst(rst), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
		.sfr_rdata_q(sfr_rdata_q), .acc_req(acc_req),
		.acc_write(acc_write), .acc_short(acc_short), .acc_addr(acc_addr),
		.acc_wdata(acc_wdata), .acc_done_q(acc_done_q),
		.acc_rdata_q(acc_rdata_q), .mem_addr_q(mem_addr_q),
		.mem_addr_hi_oe_q(mem_addr_hi_oe_q), .mem_data_out_q(mem_data_out_q),
		.mem_data_oe_q(mem_data_oe_q), .mem_data_in(mem_data_in),
		.mem_ale_q(mem_ale_q), .mem_rd_n_q(mem_rd_n_q),
		.mem_wr_n_q(mem_wr_n_q));
	emt_mem_model mem (.clk_sys(clk_sys), .muxed(muxed),
		.mem_addr_q(mem_addr_q), .mem_data_out_q(mem_data_out_q),
		.mem_ale_q(mem_ale_q), .mem_rd_n_q(mem_rd_n_q),
		.mem_wr_n_q(mem_wr_n_q), .mem_data_in(mem_data_in));
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s exp %0h seen %0h", nm, exp, seen);
		end
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic tick;
		@(posedge clk_sys);
		#1;
	endtask
	task automatic reg_wr(logic [7:0] a, logic [7:0] d);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		tick;
		sfr_wr = 1'b0;
		tick;
	endtask
	task automatic reg_rd(logic [7:0] a, output logic [7:0] d);
		sfr_addr = a;
		sfr_rd = 1'b1;
		tick;
		sfr_rd = 1'b0;
		d = sfr_rdata_q;
		tick;
	endtask
	task automatic access(logic w, logic s, logic [15:0] a, logic [7:0] d);
		acc_write = w;
		acc_short = s;
		acc_addr = a;
		acc_wdata = d;
		acc_req = 1'b1;
		{sw_c, al_c, bs_c, bw_c, ba_c, ho_c, wd_c, ad_c} = '0;
		tick;
		acc_req = 1'b0;
		lat_c = 1;
		while (acc_done_q !== 1'b1 && lat_c < 60) begin
			if (w ? mem_rd_n_q !== 1'b1 : mem_wr_n_q !== 1'b1)
				bs_c++;
			if (mem_rd_n_q === 1'b0 || mem_wr_n_q === 1'b0) begin
				sw_c++;
				ho_c = mem_addr_hi_oe_q;
				if (w && (mem_data_oe_q !== 1'b1 || mem_data_out_q !== d))
					bw_c++;
			end
			if (mem_ale_q === 1'b1) begin
				al_c++;
				if (mem_data_oe_q !== 1'b1 || mem_data_out_q !== a[7:0])
					ba_c++;
			end
			if (mem_data_oe_q === 1'b1 && mem_ale_q !== 1'b1)
				wd_c++;
			if (mem_addr_hi_oe_q === 1'b1 &&
				mem_addr_q[15:8] !== a[15:8])
				ad_c++;
			if (!muxed && mem_addr_q[7:0] !== a[7:0])
				ad_c++;
			tick;
			lat_c++;
		end
		if (lat_c >= 60) begin
			chk("access timeout", 1, 0);
			results();
		end
	endtask
	initial begin
		muxed = 1'b0;
		repeat (10) tick;
		rst = 1'b0;
		reg_rd(EMT_TIMING_ADDR, rv);
		chk("timing reset", rv, EMT_TIMING_RST);
		reg_rd(EMT_CONFIG_ADDR, rv);
		chk("config reset", rv, EMT_CONFIG_RST);
		reg_wr(EMT_CONFIG_ADDR, 8'hFF);
		reg_wr(8'h90, 8'h00);
		reg_rd(EMT_CONFIG_ADDR, rv);
		chk("config mask", rv, 8'h1F);
		reg_rd(8'h90, rv);
		chk("unmapped read", rv, 8'h00);
		$display("test registers done");
		for (int i = 0; i < 6; i++) begin
			reg_wr(EMT_TIMING_ADDR, tms[i]);
			reg_wr(EMT_CONFIG_ADDR, cfs[i]);
			reg_rd(EMT_TIMING_ADDR, rv);
			chk("timing readback", rv, tms[i]);
			muxed = !cfs[i][4] && cfs[i][4:2] != 3'h0;
			xa = muxed ? cfs[i][1:0] + 1 : 0;
			xl = EMT_BASE_CYCLES + tms[i][7:6] + tms[i][5:2] + 1
				+ tms[i][1:0] + 2 * xa;
			for (int w = 1; w >= 0; w--) begin
				access(w, shs[i], {8'hA0 + 8'(i), 8'h31 + 8'(i)}, 8'hC3 ^ 8'(i));
				chk("access cycles", lat_c, xl);
				chk("strobe width", sw_c, tms[i][5:2] + 1);
				chk("latch high", al_c, xa);
				chk("one strobe", bs_c, 0);
				chk("write data", bw_c, 0);
				chk("latched addr", ba_c, 0);
				chk("data drive", wd_c, w ? tms[i][7:6] + tms[i][5:2] + 1 +
					tms[i][1:0] : 0);
				chk("address", ad_c, 0);
				chk("upper drive", ho_c, !shs[i] || cfs[i][3:2] == 2'h2);
				if (w == 0 && tms[i][5:2] > 4'h2)
					chk("read data", acc_rdata_q, 8'hC3 ^ 8'(i));
			end
			$display("test mode %0d done", i);
		end
		rst = 1'b1;
		repeat (2) tick;
		rst = 1'b0;
		reg_rd(EMT_TIMING_ADDR, rv);
		chk("timing after reset", rv, EMT_TIMING_RST);
		$display("test reset done");
		results();
	end
endmodule
